// ### src/gpcr_pkg.sv
// constants, register map and carrier types of the pack configuration and relax control block
// assumes a 100 MHz system clock and 32-bit apb with byte addresses on paddr
package gpcr_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFS_PACK_CFG = 8'h00;
  localparam logic [7:0] OFS_ENERGY_SCALE = 8'h04;
  localparam logic [7:0] OFS_SET_BASE = 8'h08;
  localparam logic [7:0] OFS_SET_LAST = 8'h1c;
  localparam logic [7:0] OFS_LEARN = 8'h20;
  localparam logic [7:0] OFS_AVG_I = 8'h24;
  localparam logic [7:0] OFS_AVG_P = 8'h28;
  localparam logic [7:0] OFS_DELTA_V = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_LEARN_CMD = 8'h34;
  // nonvolatile home of the pack configuration word
  localparam logic [7:0] NV_SUBCLASS = 8'h40;
  localparam logic [7:0] NV_OFFSET = 8'h00;
  // setting word indices inside the settings memory
  localparam int unsigned SET_DSG_THR = 0;
  localparam int unsigned SET_CHG_THR = 1;
  localparam int unsigned SET_QUIT_CUR = 2;
  localparam int unsigned SET_DSG_RELAX = 3;
  localparam int unsigned SET_CHG_RELAX = 4;
  localparam int unsigned SET_QUIT_RELAX = 5;
  localparam int unsigned SET_WORDS = 6;
  localparam int unsigned SET_WIDTH = 16;
  // settings reset values, word 0 in the low bits
  localparam logic [95:0] SET_RST = {16'h0001, 16'h003c, 16'h003c, 16'h0028, 16'h004b, 16'h003c};
  // pack configuration bit positions
  localparam int unsigned PB_NOLOAD_RES = 15;
  localparam int unsigned PB_CALIB_ALLOW = 14;
  localparam int unsigned PB_DIVIDER = 11;
  localparam int unsigned PB_WAKE_EN = 10;
  localparam int unsigned PB_WAKE_HI = 9;
  localparam int unsigned PB_WAKE_LO = 8;
  localparam int unsigned PB_TIMES_TEN = 7;
  localparam int unsigned PB_RES_STEP = 6;
  localparam int unsigned PB_SLEEP = 5;
  localparam int unsigned PB_RM_FULL = 4;
  localparam int unsigned PB_THERM = 0;
  localparam logic [15:0] PACK_RST = 16'h0171;
  localparam logic [15:0] PACK_MASK = 16'hcff1;
  // energy scale values
  localparam logic [7:0] SCALE_ONE = 8'h01;
  localparam logic [7:0] SCALE_TEN = 8'h0a;
  localparam logic [7:0] SCALE_RST = SCALE_ONE;
  // learning state codes
  localparam logic [7:0] LEARN_DONE_OFF = 8'h02;
  localparam logic [7:0] LEARN_ON_NONE = 8'h04;
  localparam logic [7:0] LEARN_ON_QMAX = 8'h05;
  localparam logic [7:0] LEARN_ON_FULL = 8'h06;
  localparam logic [7:0] LEARN_RST = LEARN_DONE_OFF;
  // voltage slope limit for capacity update, microvolts per second
  localparam logic [15:0] DVDT_LIMIT = 16'h0004;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned OCV_DELAY_MIN = 6;
  localparam logic [15:0] OCV_DELAY_S = 16'(OCV_DELAY_MIN * 60);

  // one measurement sample from the gauge front end
  typedef struct packed {
    logic valid;
    logic signed [15:0] mean_current;
    logic signed [15:0] inst_current;
    logic [15:0] voltage;
    logic [15:0] dvdt;
    logic spike;
  } gpcr_meas_s;

  // decoded configuration towards the rest of the gauge
  typedef struct packed {
    logic noload_reserve_comp;
    logic divider_select;
    logic current_wake_en;
    logic wake_sense_sel_hi;
    logic wake_sense_sel_lo;
    logic times_ten_scale;
    logic res_factor_step_en;
    logic thermistor_select;
    logic scale_ten;
  } gpcr_cfg_s;

  typedef enum logic {RLX_FLOWING, RLX_RELAXED} gpcr_relax_e;
endpackage

// ### src/gpcr_setmem.sv
// small settings memory: thresholds and relax times
// assumes one write port and one registered read port, plus a parallel view for the logic
`timescale 1ns/100ps
module gpcr_setmem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 6,
  parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [WIDTH*DEPTH-1:0] words_o
);
  // index width is fixed at three bits
  if (DEPTH < 1 || DEPTH > 8) $error("depth out of range");

  logic [WIDTH-1:0] mem [DEPTH]; // the words themselves

  // storage with reset defaults, a write past the end is dropped
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= INIT[i*WIDTH +: WIDTH];
      rdata_o <= '0;
    end
    else
    begin
      if (we_i && 32'(waddr_i) < DEPTH)
        mem[waddr_i] <= wdata_i;
      rdata_o <= (32'(raddr_i) < DEPTH) ? mem[raddr_i] : '0;
    end
  end

  // parallel view for the thresholds and timers
  always_comb
  begin
    words_o = '0;
    for (int i = 0; i < DEPTH; i++)
      words_o[i*WIDTH +: WIDTH] = mem[i];
  end
endmodule

// ### src/gpcr_top.sv
// pack configuration register bank with relax detection and capacity learning state
// assumes an apb master on clk_sys_i and measurement samples from logic on the same clock
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module gpcr_top #(
  parameter int unsigned TICK_CYCLES = gpcr_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input gpcr_pkg::gpcr_meas_s meas_i,
  input wire logic learn_ra_i,
  input wire logic calib_req_i,
  input wire logic sleep_ok_i,
  input wire logic charge_term_i,
  output gpcr_pkg::gpcr_cfg_s cfg_o,
  output logic relaxed_o,
  output logic ocv_active_o,
  output logic qmax_update_o,
  output logic dsg_flow_o,
  output logic chg_flow_o,
  output logic calib_mode_o,
  output logic sleep_allow_o,
  output logic rm_load_fcc_o
);
  import gpcr_pkg::*;

  // a zero tick would never let a second pass
  if (TICK_CYCLES < 1) $error("tick cycles must be positive");

  // magnitude of a signed sample, -32768 maps to 32768 without overflow
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // saturating seconds counter step
  function automatic logic [15:0] sec_step(input logic [15:0] c, input logic tick);
    return (tick && c != 16'hffff) ? 16'(c + 16'h0001) : c;
  endfunction

  // condition held long enough; the first tick may land one cycle after the
  // condition starts, so one count past the setting guarantees the full time
  function automatic logic held_for(input logic [15:0] s, input logic [15:0] t);
    return t == 16'h0000 || s > t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_q1; // first stage, read only by the second
  logic rst_n; // released reset for the whole block

  // asynchronous assert, two-stage release
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = psel_i && !penable_i; // address phase
  wire access = psel_i && penable_i; // data phase, always ready
  wire [7:0] ofs = {paddr_i[7:2], 2'b00}; // word aligned byte offset
  wire set_hit = ofs >= OFS_SET_BASE && ofs <= OFS_SET_LAST;
  wire [2:0] set_idx = 3'((ofs - OFS_SET_BASE) >> 2);
  wire known = set_hit || ofs == OFS_PACK_CFG || ofs == OFS_ENERGY_SCALE
               || ofs == OFS_LEARN || ofs == OFS_AVG_I || ofs == OFS_AVG_P
               || ofs == OFS_DELTA_V || ofs == OFS_STATUS || ofs == OFS_LEARN_CMD;
  wire wr = access && pwrite_i;
  wire [7:0] scale_wdata = pwdata_i[7:0];
  // only one or ten may be stored; anything else is refused
  wire scale_bad = pwdata_i[31:8] != 24'h000000
                   || (scale_wdata != SCALE_ONE && scale_wdata != SCALE_TEN);
  wire wr_pack = wr && ofs == OFS_PACK_CFG;
  wire wr_scale = wr && ofs == OFS_ENERGY_SCALE && !scale_bad;
  wire wr_set = wr && set_hit;
  wire learn_cmd = wr && ofs == OFS_LEARN_CMD && pwdata_i[0];

  assign pready_o = 1'b1;
  assign pslverr_o = access && (!known || (pwrite_i && ofs == OFS_ENERGY_SCALE && scale_bad));

  ////////////////////////////////////////////////////////////////////////////////
  // configuration storage

  logic [15:0] pack_cfg; // copy of the nonvolatile word at NV_SUBCLASS / NV_OFFSET
  logic [7:0] energy_scale; // unit scale of the energy settings

  // reserved positions are masked on write so they always read zero
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pack_cfg <= PACK_RST;
      energy_scale <= SCALE_RST;
    end
    else
    begin
      if (wr_pack)
        pack_cfg <= pwdata_i[15:0] & PACK_MASK;
      if (wr_scale)
        energy_scale <= scale_wdata;
    end
  end

  logic [2:0] mem_raddr;
  logic [15:0] mem_rdata; // registered read of the settings
  logic [95:0] set_words; // parallel view of all settings

  gpcr_setmem #(
    .WIDTH(SET_WIDTH),
    .DEPTH(SET_WORDS),
    .INIT(SET_RST)
  ) u_setmem (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .we_i(wr_set),
    .waddr_i(set_idx),
    .wdata_i(pwdata_i[15:0]),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata),
    .words_o(set_words)
  );
  assign mem_raddr = set_idx;

  wire [15:0] dsg_thr = set_words[SET_DSG_THR*SET_WIDTH +: SET_WIDTH];
  wire [15:0] chg_thr = set_words[SET_CHG_THR*SET_WIDTH +: SET_WIDTH];
  wire [15:0] quit_cur = set_words[SET_QUIT_CUR*SET_WIDTH +: SET_WIDTH];
  wire [15:0] dsg_relax = set_words[SET_DSG_RELAX*SET_WIDTH +: SET_WIDTH];
  wire [15:0] chg_relax = set_words[SET_CHG_RELAX*SET_WIDTH +: SET_WIDTH];
  wire [15:0] quit_relax = set_words[SET_QUIT_RELAX*SET_WIDTH +: SET_WIDTH];

  // the times ten bit is only reported; no logic here looks at it
  assign cfg_o = '{
    noload_reserve_comp: pack_cfg[PB_NOLOAD_RES],
    divider_select: pack_cfg[PB_DIVIDER],
    current_wake_en: pack_cfg[PB_WAKE_EN],
    wake_sense_sel_hi: pack_cfg[PB_WAKE_HI],
    wake_sense_sel_lo: pack_cfg[PB_WAKE_LO],
    times_ten_scale: pack_cfg[PB_TIMES_TEN],
    res_factor_step_en: pack_cfg[PB_RES_STEP],
    thermistor_select: pack_cfg[PB_THERM],
    scale_ten: energy_scale == SCALE_TEN
  };

  ////////////////////////////////////////////////////////////////////////////////
  // current direction and seconds tick

  wire [15:0] mag = mag16(meas_i.mean_current);
  wire below = mag < quit_cur; // quiet current
  wire above = mag > quit_cur; // current flowing
  // signed compare against the negated discharge threshold
  wire dsg_now = 17'(signed'(meas_i.mean_current)) < -17'(signed'({1'b0, dsg_thr}));
  wire chg_now = 17'(signed'(meas_i.mean_current)) > 17'(signed'({1'b0, chg_thr}));

  logic [31:0] tick_cnt;
  wire sec_tick = tick_cnt == 32'(TICK_CYCLES - 1);

  // free-running divider to one-second ticks
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else
      tick_cnt <= sec_tick ? '0 : 32'(tick_cnt + 32'h00000001);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // relaxation state

  gpcr_relax_e relax, next_relax;
  logic [15:0] below_s, above_s, relax_s; // seconds in each condition
  logic qmax_done; // one capacity update per relaxed stretch

  wire enter = (below && held_for(below_s, dsg_relax))
               || (above && held_for(above_s, chg_relax));
  wire leave = above && held_for(above_s, quit_relax);
  wire slope_ok = meas_i.dvdt < DVDT_LIMIT;

  // next state of the relax detector
  always_comb
  begin
    next_relax = relax;
    case (relax)
      RLX_FLOWING:
        if (enter)
          next_relax = RLX_RELAXED;
      RLX_RELAXED:
        if (leave)
          next_relax = RLX_FLOWING;
      default:
        next_relax = RLX_FLOWING;
    endcase
  end

  wire change = next_relax != relax; // restart the condition timers
  wire ocv_now = relax == RLX_RELAXED && relax_s >= OCV_DELAY_S;

  // condition timers restart on every state change so the seconds counted to enter
  // relaxation cannot also count toward leaving it
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      relax <= RLX_FLOWING;
      below_s <= '0;
      above_s <= '0;
      relax_s <= '0;
      qmax_done <= 1'b0;
      qmax_update_o <= 1'b0;
    end
    else
    begin
      relax <= next_relax;
      below_s <= (change || !below) ? '0 : sec_step(below_s, sec_tick);
      above_s <= (change || !above) ? '0 : sec_step(above_s, sec_tick);
      relax_s <= (change || relax != RLX_RELAXED) ? '0 : sec_step(relax_s, sec_tick);
      // the pulse itself blocks a repeat before the done flag has landed
      qmax_update_o <= ocv_now && !change && meas_i.valid && slope_ok && !qmax_done
                       && !qmax_update_o;
      if (change)
        qmax_done <= 1'b0;
      else if (qmax_update_o)
        qmax_done <= 1'b1;
    end
  end

  assign relaxed_o = relax == RLX_RELAXED;
  assign ocv_active_o = ocv_now;

  ////////////////////////////////////////////////////////////////////////////////
  // learning state and gates

  logic [7:0] learn, next_learn;

  // only the enable command or progress inside a learning cycle moves the code
  always_comb
  begin
    next_learn = learn;
    if (learn_cmd && learn == LEARN_DONE_OFF)
      next_learn = LEARN_ON_FULL;
    else if (learn == LEARN_ON_NONE && qmax_update_o)
      next_learn = learn_ra_i ? LEARN_ON_FULL : LEARN_ON_QMAX;
    else if (learn == LEARN_ON_QMAX && learn_ra_i)
      next_learn = LEARN_ON_FULL;
  end

  // learning code and the registered gate outputs
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      learn <= LEARN_RST;
      dsg_flow_o <= 1'b0;
      chg_flow_o <= 1'b0;
      calib_mode_o <= 1'b0;
      sleep_allow_o <= 1'b0;
      rm_load_fcc_o <= 1'b0;
    end
    else
    begin
      learn <= next_learn;
      dsg_flow_o <= dsg_now;
      chg_flow_o <= chg_now;
      calib_mode_o <= calib_req_i && pack_cfg[PB_CALIB_ALLOW];
      sleep_allow_o <= sleep_ok_i && pack_cfg[PB_SLEEP];
      rm_load_fcc_o <= charge_term_i && pack_cfg[PB_RM_FULL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // last-run averages and spike delta

  logic signed [47:0] sum_i; // current over the running discharge cycle
  logic signed [63:0] sum_p; // power over the running discharge cycle
  logic [31:0] n_smp; // samples in the running cycle
  logic signed [15:0] avg_i; // previous cycle average current
  logic signed [31:0] avg_p; // previous cycle average power
  logic [15:0] base_v, delta_v; // normal-load voltage and largest dip
  wire signed [32:0] pwr = meas_i.inst_current * signed'({1'b0, meas_i.voltage});
  wire dsg_end = dsg_flow_o && !dsg_now && n_smp != 32'h00000000;
  wire signed [32:0] n_div = signed'({1'b0, n_smp});
  wire [15:0] dip = 16'(base_v - meas_i.voltage);

  // the divide is a single wide combinational path; it runs once per cycle end
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum_i <= '0;
      sum_p <= '0;
      n_smp <= '0;
      avg_i <= '0;
      avg_p <= '0;
    end
    else if (dsg_end)
    begin
      avg_i <= 16'(sum_i / n_div);
      avg_p <= 32'(sum_p / n_div);
      sum_i <= '0;
      sum_p <= '0;
      n_smp <= '0;
    end
    else if (dsg_now && meas_i.valid)
    begin
      sum_i <= 48'(sum_i + meas_i.inst_current);
      sum_p <= 64'(sum_p + pwr);
      n_smp <= 32'(n_smp + 32'h00000001);
    end
  end

  // base follows normal samples, spikes only ever raise the kept maximum
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_v <= '0;
      delta_v <= '0;
    end
    else if (meas_i.valid)
    begin
      if (!meas_i.spike)
        base_v <= meas_i.voltage;
      else if (base_v > meas_i.voltage && dip > delta_v)
        delta_v <= dip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] rd_q; // flop read data, captured in the setup cycle
  logic set_q; // the access reads the settings memory
  logic [31:0] rd_mux;

  // read selection, unmapped and write-only offsets read zero
  always_comb
  begin
    case (ofs)
      OFS_PACK_CFG: rd_mux = {16'h0000, pack_cfg};
      OFS_ENERGY_SCALE: rd_mux = {24'h000000, energy_scale};
      OFS_LEARN: rd_mux = {24'h000000, learn};
      OFS_AVG_I: rd_mux = {16'h0000, avg_i};
      OFS_AVG_P: rd_mux = avg_p;
      OFS_DELTA_V: rd_mux = {16'h0000, delta_v};
      OFS_STATUS: rd_mux = {26'h0, qmax_done, chg_flow_o, dsg_flow_o, calib_mode_o,
                            ocv_now, relaxed_o};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // capture at setup so the access phase needs no wait state
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= '0;
      set_q <= 1'b0;
    end
    else if (setup)
    begin
      rd_q <= rd_mux;
      set_q <= set_hit;
    end
  end

  assign prdata_o = set_q ? {16'h0000, mem_rdata} : rd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  chk_scale_legal: assert property (energy_scale == SCALE_ONE || energy_scale == SCALE_TEN)
    else $error("energy scale holds an illegal value");
  chk_reserved_zero: assert property ((pack_cfg & ~PACK_MASK) == 16'h0000)
    else $error("reserved config bit set");
  chk_learn_codes: assert property (learn == LEARN_DONE_OFF || learn == LEARN_ON_NONE
      || learn == LEARN_ON_QMAX || learn == LEARN_ON_FULL)
    else $error("learning code out of set");
  chk_learn_cause: assert property (!$stable(learn) |->
      $past(learn_cmd) || $past(qmax_update_o) || $past(learn_ra_i))
    else $error("learning code moved without cause");
  chk_ocv_delay: assert property ($rose(ocv_active_o) |-> relaxed_o && relax_s == OCV_DELAY_S)
    else $error("open circuit phase started early");
  chk_qmax_slope: assert property (qmax_update_o |-> $past(slope_ok && ocv_now))
    else $error("capacity update without relaxed slope");
  chk_relax_exit: assert property ($fell(relaxed_o) |->
      $past(above && (quit_relax == 16'h0000 || above_s > quit_relax)))
    else $error("relax left too early");
  chk_qmax_once: assert property (qmax_update_o |=> !qmax_update_o)
    else $error("capacity update pulse longer than one cycle");
  chk_calib_gate: assert property (calib_mode_o |-> $past(pack_cfg[PB_CALIB_ALLOW]))
    else $error("calibration without allow bit");
  chk_rm_full: assert property (charge_term_i && pack_cfg[PB_RM_FULL] |=> rm_load_fcc_o)
    else $error("remaining not loaded on termination");
  chk_sleep_gate: assert property (!pack_cfg[PB_SLEEP] |=> !sleep_allow_o)
    else $error("sleep allowed with bit clear");
endmodule

// ### tb/gpcr_host.sv
// apb master standing in for host software that configures the gauge
// assumes a slave on the same clock; waits for pready with no fixed latency
`timescale 1ns/100ps
module gpcr_host (
  input wire logic clk_sys_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [7:0] paddr_o = 8'h00,
  output logic [31:0] pwdata_o = 32'h0
);
  ////////////////////////////////////////////////////////////////////////////////
  // one transfer; a leading edge keeps a release and the next setup apart
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_sys_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    // request held until pready is seen at an edge
    do
      @(posedge clk_sys_i);
    while (pready_i !== 1'b1);
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// ### tb/gauge_pack_config_relax_control_tb.sv
// self-checking bench of the pack configuration and relax control block
// assumes gpcr_pkg compiled first; short second tick keeps relax timing brief
`timescale 1ns/100ps
module gauge_pack_config_relax_control_tb;
  import gpcr_pkg::*;
  localparam int unsigned TICK = 4; // cycles per simulated second
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  wire logic psel, penable, pwrite;
  wire logic [7:0] paddr;
  wire logic [31:0] pwdata;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  gpcr_meas_s meas = '0;
  logic learn_ra = 1'b0, calib_req = 1'b0, sleep_ok = 1'b0, charge_term = 1'b0;
  gpcr_cfg_s cfg;
  logic relaxed, open_circuit_voltage, qmax, dsg, chg, calib, sleep_allow, rm_load;
  int miscompares = 0, n_tests = 0, cyc = 0, n;
  always #5 clk_sys_i = ~clk_sys_i;
  gpcr_host host_u (.clk_sys_i(clk_sys_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  gpcr_top #(.TICK_CYCLES(TICK)) dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .meas_i(meas), .learn_ra_i(learn_ra), .calib_req_i(calib_req), .sleep_ok_i(sleep_ok),
    .charge_term_i(charge_term), .cfg_o(cfg), .relaxed_o(relaxed), .ocv_active_o(open_circuit_voltage),
    .qmax_update_o(qmax), .dsg_flow_o(dsg), .chg_flow_o(chg), .calib_mode_o(calib),
    .sleep_allow_o(sleep_allow), .rm_load_fcc_o(rm_load));
  ////////////////////////////////////////////////////////////////////////////////
  // helpers; outputs read right after an edge show the previous cycle's value
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      $display("wrong value %s expected %h seen %h", nm, x, g);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, q, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, gating inputs
  task automatic t_reset();
    rd(8'h00);
    chk("pack", 32'h00000171, q);
    chk("cfg", 32'h00000016, {23'h0, cfg});
    rd(8'h20);
    chk("learn", 32'h2, q);
    sleep_ok <= 1'b1;
    calib_req <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("sleep", 32'h1, {31'h0, sleep_allow});
    chk("calib", 32'h0, {31'h0, calib});
  endtask
  // every bit set: reserved bits dropped, gates open
  task automatic t_cfg();
    wr(8'h00, 32'hffffffff);
    rd(8'h00);
    chk("pack", 32'h0000cff1, q);
    chk("cfg", 32'h000001fe, {23'h0, cfg});
    chk("calib", 32'h1, {31'h0, calib});
    charge_term <= 1'b1;
    @(posedge clk_sys_i);
    charge_term <= 1'b0;
    @(posedge clk_sys_i);
    chk("rm_load", 32'h1, {31'h0, rm_load});
  endtask
  // scale refusal, unmapped and read-only places, learning command
  task automatic t_scale();
    wr(8'h04, 32'ha);
    wr(8'h04, 32'h5);
    chk("scale_err", 32'h1, {31'h0, e});
    rd(8'h04);
    chk("scale", 32'ha, q);
    rd(8'h3c);
    chk("unmapped_err", 32'h1, {31'h0, e});
    wr(8'h20, 32'h4);
    rd(8'h20);
    chk("learn_ro", 32'h2, q);
    wr(8'h34, 32'h1);
    rd(8'h20);
    chk("learn_cmd", 32'h6, q);
  endtask
  // relax entry, ocv delay, capacity update, exit, flow, last-run averages
  task automatic t_relax();
    wr(8'h14, 32'h1);
    rd(8'h14);
    chk("dsg_relax", 32'h1, q);
    meas.mean_current <= 16'sd0;
    n = 0;
    while (relaxed !== 1'b1 && n < 60) begin @(posedge clk_sys_i); n++; end
    chk("relaxed", 32'h1, {31'h0, relaxed});
    rd(8'h30);
    chk("status", 32'h5, q);
    n = 0;
    while (open_circuit_voltage !== 1'b1 && n < 2000) begin @(posedge clk_sys_i); n++; end
    chk("ocv_late", 32'h1, {31'h0, n >= 360 * TICK - 10 && n < 2000});
    meas.valid <= 1'b1;
    meas.dvdt <= 16'h4;
    repeat (3) @(posedge clk_sys_i);
    chk("qmax_slope", 32'h0, {31'h0, qmax});
    meas.dvdt <= 16'h3;
    n = 0;
    while (qmax !== 1'b1 && n < 5) begin @(posedge clk_sys_i); n++; end
    chk("qmax", 32'h1, {31'h0, qmax});
    @(posedge clk_sys_i);
    chk("qmax_once", 32'h0, {31'h0, qmax});
    meas.valid <= 1'b0;
    meas.mean_current <= 16'sd100;
    n = 0;
    while (relaxed !== 1'b0 && n < 40) begin @(posedge clk_sys_i); n++; end
    chk("exit", 32'h1, {31'h0, n >= TICK && n < 40});
    chk("chg", 32'h1, {31'h0, chg});
    meas.mean_current <= -16'sd100;
    meas.inst_current <= -16'sd100;
    meas.voltage <= 16'd10;
    meas.valid <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk("dsg", 32'h1, {31'h0, dsg});
    meas.spike <= 1'b1;
    meas.voltage <= 16'd4;
    @(posedge clk_sys_i);
    meas.valid <= 1'b0;
    meas.mean_current <= 16'sd0;
    repeat (4) @(posedge clk_sys_i);
    rd(8'h2c);
    chk("delta_v", 32'h6, q);
    rd(8'h24);
    chk("avg_i", 32'hff9c, {16'h0, q[15:0]});
    rd(8'h28);
    chk("avg_p", 32'hfffffc6e, q);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results();
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard well above the ~1550 cycles the tests need
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end
  // mean current starts between quit and charge thresholds so no early relax
  initial
  begin
    meas.mean_current <= 16'sd50;
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_cfg();
    t_scale();
    t_relax();
    results();
  end
endmodule
